// ### core/sup_pkg.sv
// Constants for the sector unprotect and global protect logic.
// Summary of operation
// - Unprotect is opcode then three address bytes
// - Unprotect runs only with write latch set
// - Bytes after the address are discarded
// - Frame end clears sector flag and latch
// - Short or misaligned frame aborts, clears latch
// - Lock bit set aborts unprotect, clears latch
// - One protection flag per sector, one blocks
// - Status bits 5..2 all ones protect all
// - Status bits 5..2 all zeros unprotect all
// - Status write loads lock bit from bit 7
// - Global protect with suspension aborts, clears latch
// - Whole write-enable opcode sets latch at frame end
`default_nettype none
package sup_pkg;
	localparam int          SUP_NSECT        = 32;
	localparam int          SUP_SECT_W       = 5;
	localparam int          SUP_SECT_LSB     = 16;
	localparam int          SUP_ADDR_W       = 24;
	localparam logic [7:0]  SUP_OPC_WREN     = 8'h06;
	localparam logic [7:0]  SUP_OPC_WRDI     = 8'h04;
	localparam logic [7:0]  SUP_OPC_UNPROT   = 8'h39;
	localparam logic [7:0]  SUP_OPC_WRSR1    = 8'h01;
	localparam logic [1:0]  SUP_UNPROT_NARG  = 2'h3;
	localparam logic [1:0]  SUP_WRSR_NARG    = 2'h1;
	localparam int          SUP_LOCK_POS     = 7;
	localparam int          SUP_GLOB_HI      = 5;
	localparam int          SUP_GLOB_LO      = 2;
	localparam logic [3:0]  SUP_GLOB_ONES    = 4'hF;
	localparam logic [3:0]  SUP_GLOB_ZEROS   = 4'h0;
	localparam logic [31:0] SUP_PROT_RESET   = 32'hFFFFFFFF;
	localparam logic        SUP_LOCK_RESET   = 1'b0;
	localparam logic        SUP_WEL_RESET    = 1'b0;
	localparam logic [2:0]  SUP_BITCNT_RESET = 3'h0;

	typedef enum logic [2:0]
	{
		SUP_ST_OPCODE  = 3'b001,
		SUP_ST_ARGS    = 3'b010,
		SUP_ST_DISCARD = 3'b100
	} sup_state_t;
endpackage : sup_pkg
`default_nettype wire

// ### core/sup_spi_shifter.sv
// Serial byte assembler: samples SI on rising SCK while chip select is low.
`default_nettype none
module sup_spi_shifter
	import sup_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       si,
	output logic            byte_vld,
	output logic [7:0]      byte_data,
	output logic            frame_end,
	output logic            aligned
);
	logic       sck_r;
	logic       cs_n_r;
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic       sck_rise;

	assign sck_rise  = sck && !sck_r && !cs_n;
	assign frame_end = cs_n && !cs_n_r;
	// Byte boundary test on the count held at the chip select edge
	assign aligned   = (bit_cnt_r == SUP_BITCNT_RESET);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sck_r  <= 1'b0;
			cs_n_r <= 1'b1;
		end
		else
		begin
			sck_r  <= sck;
			cs_n_r <= cs_n;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bit_cnt_r <= SUP_BITCNT_RESET;
			shift_r   <= 7'h00;
			byte_vld  <= 1'b0;
			byte_data <= 8'h00;
		end
		else
		begin
			byte_vld <= 1'b0;
			// Counter is kept through the rising edge so frame_end sees it
			if (cs_n && cs_n_r)
				bit_cnt_r <= SUP_BITCNT_RESET;
			else if (sck_rise)
			begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				shift_r   <= {shift_r[5:0], si};
				if (bit_cnt_r == 3'h7)
				begin
					byte_vld  <= 1'b1;
					byte_data <= {shift_r, si};
				end
			end
		end
	end
endmodule : sup_spi_shifter
`default_nettype wire

// ### core/sup_sector_flags.sv
// Per-sector protection flags with single and global update ports.
`default_nettype none
module sup_sector_flags
	import sup_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  clr_one,
	input  wire logic [SUP_SECT_W-1:0] sel,
	input  wire logic                  set_all,
	input  wire logic                  clr_all,
	output logic      [SUP_NSECT-1:0]  flags
);
	genvar g;
	generate
		for (g = 0; g < SUP_NSECT; g++)
		begin : g_sect
			// Power-up leaves every sector protected
			always_ff @(posedge clk)
			begin
				if (rst)
					flags[g] <= SUP_PROT_RESET[g];
				else if (set_all)
					flags[g] <= 1'b1;
				else if (clr_all || (clr_one && (sel == SUP_SECT_W'(g))))
					flags[g] <= 1'b0;
			end
		end
	endgenerate
endmodule : sup_sector_flags
`default_nettype wire

// ### core/sup_top.sv
// Command decode for write enable, sector unprotect and global protect.
`default_nettype none
module sup_top
	import sup_pkg::*;
(
	input  wire logic                 CORE_CLK,
	input  wire logic                 RESET,
	input  wire logic                 CS_N,
	input  wire logic                 SCK,
	input  wire logic                 SI,
	input  wire logic                 WP_N,
	input  wire logic                 SUSPENDED,
	output logic     [SUP_NSECT-1:0]  SECTOR_PROTECT,
	output logic                      WRITE_ENABLE_LATCH,
	output logic                      PROTECTION_LOCK_BIT,
	output logic                      CMD_ABORT
);
	logic                  byte_vld;
	logic [7:0]            byte_data;
	logic                  frame_end;
	logic                  aligned;
	sup_state_t            state_r;
	logic [7:0]            opc_r;
	logic [1:0]            narg_r;
	logic [1:0]            need;
	logic [SUP_ADDR_W-1:0] addr_r;
	logic [7:0]            stat_r;
	logic                  wel_r;
	logic                  lock_r;
	logic                  abort_r;
	logic                  has_opc;
	logic                  unp_cmd;
	logic                  unp_go;
	logic                  wrsr_cmd;
	logic                  wrsr_ok;
	logic                  hard_lock;
	logic                  glob_ones;
	logic                  glob_zeros;
	logic                  susp_abort;
	logic                  set_all;
	logic                  clr_all;
	logic                  wren_ok;
	logic                  wrdi_ok;

	sup_spi_shifter u_shift
	(
		.clk       (CORE_CLK),
		.rst       (RESET),
		.cs_n      (CS_N),
		.sck       (SCK),
		.si        (SI),
		.byte_vld  (byte_vld),
		.byte_data (byte_data),
		.frame_end (frame_end),
		.aligned   (aligned)
	);

	always_comb
	begin
		case (byte_data)
			SUP_OPC_UNPROT: need = SUP_UNPROT_NARG;
			SUP_OPC_WRSR1:  need = SUP_WRSR_NARG;
			default:        need = 2'h0;
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			state_r <= SUP_ST_OPCODE;
		else if (frame_end)
			state_r <= SUP_ST_OPCODE;
		else if (byte_vld)
		begin
			case (state_r)
				SUP_ST_OPCODE:
					state_r <= (need != 2'h0) ? SUP_ST_ARGS : SUP_ST_DISCARD;
				SUP_ST_ARGS:
					if (narg_r + 2'h1 == ((opc_r == SUP_OPC_UNPROT) ? SUP_UNPROT_NARG : SUP_WRSR_NARG))
						state_r <= SUP_ST_DISCARD;
				SUP_ST_DISCARD:
					state_r <= SUP_ST_DISCARD;
				default:
					state_r <= SUP_ST_OPCODE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			opc_r  <= 8'h00;
			narg_r <= 2'h0;
			addr_r <= 24'h000000;
			stat_r <= 8'h00;
		end
		else if (frame_end)
			narg_r <= 2'h0;
		else if (byte_vld && state_r == SUP_ST_OPCODE)
			opc_r <= byte_data;
		else if (byte_vld && state_r == SUP_ST_ARGS)
		begin
			// Address arrives most significant byte first
			narg_r <= narg_r + 2'h1;
			addr_r <= {addr_r[15:0], byte_data};
			if (narg_r == 2'h0)
				stat_r <= byte_data;
		end
	end

	assign has_opc    = (state_r != SUP_ST_OPCODE);
	assign hard_lock  = lock_r && !WP_N;
	assign glob_ones  = (stat_r[SUP_GLOB_HI:SUP_GLOB_LO] == SUP_GLOB_ONES);
	assign glob_zeros = (stat_r[SUP_GLOB_HI:SUP_GLOB_LO] == SUP_GLOB_ZEROS);
	assign wren_ok    = frame_end && has_opc && aligned && opc_r == SUP_OPC_WREN;
	assign wrdi_ok    = frame_end && has_opc && aligned && opc_r == SUP_OPC_WRDI;
	assign unp_cmd    = frame_end && has_opc && opc_r == SUP_OPC_UNPROT;
	// Lock, missing latch, short or misaligned frames all fall out here
	assign unp_go     = unp_cmd && aligned && narg_r == SUP_UNPROT_NARG && wel_r && !lock_r;
	assign wrsr_cmd   = frame_end && has_opc && opc_r == SUP_OPC_WRSR1;
	assign wrsr_ok    = wrsr_cmd && aligned && narg_r == SUP_WRSR_NARG && wel_r && !hard_lock;
	assign susp_abort = wrsr_ok && glob_ones && SUSPENDED;
	assign set_all    = wrsr_ok && glob_ones && !SUSPENDED;
	assign clr_all    = wrsr_ok && glob_zeros;

	sup_sector_flags u_flags
	(
		.clk     (CORE_CLK),
		.rst     (RESET),
		.clr_one (unp_go),
		.sel     (addr_r[SUP_SECT_LSB +: SUP_SECT_W]),
		.set_all (set_all),
		.clr_all (clr_all),
		.flags   (SECTOR_PROTECT)
	);

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			wel_r <= SUP_WEL_RESET;
		else if (wren_ok)
			wel_r <= 1'b1;
		else if (wrdi_ok || unp_cmd || (wrsr_cmd && wel_r))
			wel_r <= 1'b0;
	end

	// An aborted global protect leaves the lock bit untouched as well
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			lock_r <= SUP_LOCK_RESET;
		else if (wrsr_ok && !susp_abort)
			lock_r <= stat_r[SUP_LOCK_POS];
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			abort_r <= 1'b0;
		else
			abort_r <= (unp_cmd && wel_r && !unp_go) || susp_abort;
	end

	assign WRITE_ENABLE_LATCH  = wel_r;
	assign PROTECTION_LOCK_BIT = lock_r;
	assign CMD_ABORT           = abort_r;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	chk_wren_sets_latch: assert property (wren_ok |=> WRITE_ENABLE_LATCH)
		else $error("write enable did not set latch");
	chk_unprot_needs_wel: assert property (unp_cmd && !WRITE_ENABLE_LATCH |=> $stable(SECTOR_PROTECT))
		else $error("unprotect acted without latch");
	chk_unprot_clears: assert property (unp_go |=> !SECTOR_PROTECT[$past(addr_r[20:16])] && !WRITE_ENABLE_LATCH)
		else $error("unprotect did not clear flag and latch");
	chk_unprot_short: assert property (unp_cmd && (!aligned || narg_r != 2'h3) |=> $stable(SECTOR_PROTECT) && !WRITE_ENABLE_LATCH)
		else $error("short unprotect not aborted");
	chk_unprot_locked: assert property (unp_cmd && PROTECTION_LOCK_BIT |=> $stable(SECTOR_PROTECT) && !WRITE_ENABLE_LATCH)
		else $error("locked unprotect not ignored");
	chk_extra_bytes: assert property (byte_vld && state_r == SUP_ST_DISCARD |=> $stable(addr_r) && $stable(stat_r))
		else $error("trailing byte altered arguments");
	chk_global_prot: assert property (set_all |=> SECTOR_PROTECT == 32'hFFFFFFFF && !WRITE_ENABLE_LATCH)
		else $error("global protect failed");
	chk_global_unprot: assert property (clr_all |=> SECTOR_PROTECT == 32'h00000000)
		else $error("global unprotect failed");
	chk_lock_load: assert property (wrsr_ok && !SUSPENDED |=> PROTECTION_LOCK_BIT == $past(stat_r[7]))
		else $error("lock bit not loaded from bit 7");
	chk_susp_abort: assert property (susp_abort |=> $stable(SECTOR_PROTECT) && !WRITE_ENABLE_LATCH && CMD_ABORT)
		else $error("suspended global protect not aborted");
	chk_mixed_keep: assert property (wrsr_ok && !glob_ones && !glob_zeros |=> $stable(SECTOR_PROTECT))
		else $error("mixed bits changed protection");

	cov_unprot_ok: cover property (unp_go);
	cov_global_prot: cover property (set_all);
	cov_global_unprot: cover property (clr_all);
	cov_susp_abort: cover property (susp_abort);
endmodule : sup_top
`default_nettype wire

// ### test/sup_host_model.sv
// Host serial controller model that frames commands towards the protection logic.
`default_nettype none
module sup_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sck,
	output logic      si
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// Opcode then address or status bits, MSB first; n may stop short of or off a byte edge
	task automatic frame(input logic [39:0] d, input int n);
		@(posedge clk);
		#1 cs_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			si = d[39 - i];
			repeat (2) @(posedge clk);
			#1 sck = 1'b1;
			repeat (2) @(posedge clk);
			#1 sck = 1'b0;
		end
		repeat (2) @(posedge clk);
		#1 cs_n = 1'b1;
		// A released data line must not keep looking like the last bit
		si = ~si;
		repeat (4) @(posedge clk);
		#1;
	endtask : frame
endmodule : sup_host_model
`default_nettype wire

// ### test/sup_top_test.sv
// Self-checking bench for sector unprotect and global protect commands.
`default_nettype none
module sup_top_test;
	import sup_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic                 core_clk;
	logic                 reset;
	logic                 cs_n;
	logic                 sck;
	logic                 si;
	logic                 wp_n;
	logic                 suspended;
	logic                 write_enable_latch;
	logic                 lock;
	logic                 abort;
	logic [SUP_NSECT-1:0] prot;
	logic [SUP_NSECT-1:0] exp_prot;
	int                   err_total   = 0;
	int                   comparisons = 0;
	int                   cycles      = 0;
	int                   aborts      = 0;

	sup_top dut_u (.CORE_CLK(core_clk), .RESET(reset), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
		.SUSPENDED(suspended), .SECTOR_PROTECT(prot), .WRITE_ENABLE_LATCH(write_enable_latch),
		.PROTECTION_LOCK_BIT(lock), .CMD_ABORT(abort));
	sup_host_model host_u (.clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// About 26 frames of at most about 170 cycles each; the ceiling leaves wide margin
	always @(posedge core_clk)
	begin
		cycles++;
		if (abort === 1'b1)
			aborts++;
		if (cycles == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic chk_all(input logic exp_wel, input logic exp_lock);
		check("sector flags", prot, exp_prot);
		check("write latch", {31'h0, write_enable_latch}, {31'h0, exp_wel});
		check("lock bit", {31'h0, lock}, {31'h0, exp_lock});
	endtask : chk_all

	task automatic wren();
		host_u.frame({SUP_OPC_WREN, 32'h0}, 8);
	endtask : wren

	task automatic unprot(input logic [23:0] a, input int n);
		host_u.frame({SUP_OPC_UNPROT, a, 8'hA5}, n);
	endtask : unprot

	task automatic wrsr(input logic [7:0] v);
		host_u.frame({SUP_OPC_WRSR1, v, 24'h0}, 16);
	endtask : wrsr

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	initial
	begin
		reset     = 1'b1;
		wp_n      = 1'b1;
		suspended = 1'b0;
		exp_prot  = SUP_PROT_RESET;
		repeat (6) @(posedge core_clk);
		#1 reset = 1'b0;
		chk_all(1'b0, 1'b0);
		unprot(24'h1F00AB, 32);
		chk_all(1'b0, 1'b0);
		host_u.frame({SUP_OPC_WREN, 32'h0}, 7);
		chk_all(1'b0, 1'b0);
		wren();
		chk_all(1'b1, 1'b0);
		host_u.frame({SUP_OPC_WRDI, 32'h0}, 8);
		chk_all(1'b0, 1'b0);
		wren();
		chk_all(1'b1, 1'b0);
		unprot(24'h1F00AB, 40);
		exp_prot[31] = 1'b0;
		chk_all(1'b0, 1'b0);
		wren();
		unprot(24'h000001, 32);
		exp_prot[0] = 1'b0;
		chk_all(1'b0, 1'b0);
		wren();
		unprot(24'h050000, 24);
		chk_all(1'b0, 1'b0);
		wren();
		unprot(24'h050000, 33);
		chk_all(1'b0, 1'b0);
		wren();
		wrsr(8'h00);
		exp_prot = '0;
		chk_all(1'b0, 1'b0);
		wren();
		suspended = 1'b1;
		wrsr(8'h3C);
		chk_all(1'b0, 1'b0);
		suspended = 1'b0;
		wren();
		wrsr(8'hBC);
		exp_prot = '1;
		chk_all(1'b0, 1'b1);
		wren();
		unprot(24'h050000, 32);
		chk_all(1'b0, 1'b1);
		wren();
		wrsr(8'h84);
		chk_all(1'b0, 1'b1);
		wp_n = 1'b0;
		wren();
		wrsr(8'h00);
		chk_all(1'b0, 1'b1);
		wp_n = 1'b1;
		wren();
		wrsr(8'h00);
		exp_prot = '0;
		chk_all(1'b0, 1'b0);
		check("abort pulses", aborts, 32'h4);
		give_verdict();
	end
endmodule : sup_top_test
`default_nettype wire
